//--- common/seg_bus_pkg.sv
// Shared constants for the segmented transmit bus and its two ends
package seg_bus_pkg;

	// Bus geometry
	localparam int SEG_COUNT   = 4;
	localparam int WORD_BYTES  = 16;
	localparam int WORD_W      = 128;
	localparam int EMPTY_W     = 4;
	localparam int EMPTY_LOW_W = 3;

	// Error control code byte repeated over a whole segment word
	localparam logic [7:0]        ERROR_CODE_BYTE = 8'hfe;
	localparam logic [WORD_W-1:0] ERROR_WORD      = {WORD_BYTES{ERROR_CODE_BYTE}};

	// One buffered segment: {valid, end, abort, byte enables, word}
	localparam int SLOT_W        = 3 + WORD_BYTES + WORD_W;
	localparam int SLOT_VALID    = SLOT_W - 1;
	localparam int SLOT_END      = SLOT_W - 2;
	localparam int SLOT_ABORT    = SLOT_W - 3;
	localparam int SLOT_MASK_LSB = WORD_W;

	// Statistics counters
	localparam int                CNT_W     = 16;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
	localparam logic [CNT_W-1:0]  CNT_RESET = 16'h0000;

endpackage

//--- common/seg_bus_if.sv
// Segmented transmit bus between the user packet source and the MAC transmit end
`timescale 1ns/1ps
`default_nettype none
interface seg_bus_if;

	logic [seg_bus_pkg::SEG_COUNT-1:0]                             tx_segment_valid;
	logic [seg_bus_pkg::SEG_COUNT-1:0][seg_bus_pkg::WORD_W-1:0]   tx_segment_word;
	logic [seg_bus_pkg::SEG_COUNT-1:0]                             tx_end_marker;
	logic [seg_bus_pkg::SEG_COUNT-1:0]                             tx_abort_flag;
	logic [seg_bus_pkg::SEG_COUNT-1:0][seg_bus_pkg::EMPTY_W-1:0]  tx_empty_count;
	logic                                                          tx_space;

	// Source side drives the segments, the MAC side grants room
	modport user_end (
		output tx_segment_valid,
		output tx_segment_word,
		output tx_end_marker,
		output tx_abort_flag,
		output tx_empty_count,
		input  tx_space
	);

	modport device_end (
		input  tx_segment_valid,
		input  tx_segment_word,
		input  tx_end_marker,
		input  tx_abort_flag,
		input  tx_empty_count,
		output tx_space
	);

endinterface
`default_nettype wire

//--- verilog/two_entry_buffer.sv
// Two-entry skid buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk_in,
	input  wire logic             reset_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);

	logic             out_valid_reg, out_valid_next;
	logic [WIDTH-1:0] out_data_reg,  out_data_next;
	logic             skid_valid_reg, skid_valid_next;
	logic [WIDTH-1:0] skid_data_reg,  skid_data_next;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////////////
	// Next state: output stage refills from skid first, so order is kept
	always_comb begin
		push            = in_valid_in && !skid_valid_reg;
		pop             = out_valid_reg && out_ready_in;
		out_valid_next  = out_valid_reg;
		out_data_next   = out_data_reg;
		skid_valid_next = skid_valid_reg;
		skid_data_next  = skid_data_reg;
		if (!out_valid_reg || pop) begin
			if (skid_valid_reg) begin
				out_valid_next  = 1'b1;
				out_data_next   = skid_data_reg;
				skid_valid_next = 1'b0;
			end else begin
				out_valid_next = push;
				out_data_next  = in_data_in;
			end
		end else if (push) begin
			skid_valid_next = 1'b1; // Stalled drain parks the word here
			skid_data_next  = in_data_in;
		end
	end

	// Registers
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			out_valid_reg  <= 1'b0;
			out_data_reg   <= '0;
			skid_valid_reg <= 1'b0;
			skid_data_reg  <= '0;
		end else begin
			out_valid_reg  <= out_valid_next;
			out_data_reg   <= out_data_next;
			skid_valid_reg <= skid_valid_next;
			skid_data_reg  <= skid_data_next;
		end
	end

	// Full means both entries hold a word
	assign in_ready_out  = !skid_valid_reg;
	assign out_valid_out = out_valid_reg;
	assign out_data_out  = out_data_reg;

endmodule
`default_nettype wire

//--- verilog/tx_seg_source.sv
// User end: launches packet beats onto the segmented transmit bus
`timescale 1ns/1ps
`default_nettype none
module tx_seg_source (
	input  wire logic                                                       ref_clk_in,
	input  wire logic                                                       reset_in,
	seg_bus_if.user_end                                                     bus,
	input  wire logic                                                       src_valid_in,
	output logic                                                            src_ready_out,
	input  wire logic [seg_bus_pkg::SEG_COUNT-1:0]                          src_seg_valid_in,
	input  wire logic [seg_bus_pkg::SEG_COUNT-1:0][seg_bus_pkg::WORD_W-1:0] src_word_in,
	input  wire logic [seg_bus_pkg::SEG_COUNT-1:0]                          src_last_in,
	input  wire logic [seg_bus_pkg::SEG_COUNT-1:0]                          src_bad_in,
	input  wire logic [seg_bus_pkg::SEG_COUNT-1:0][seg_bus_pkg::EMPTY_W-1:0] src_empty_in
);

	localparam int SEGS = seg_bus_pkg::SEG_COUNT;

	logic                                               ready_reg, ready_next;
	logic [SEGS-1:0]                                    valid_reg, valid_next;
	logic [SEGS-1:0][seg_bus_pkg::WORD_W-1:0]           word_reg,  word_next;
	logic [SEGS-1:0]                                    end_reg,   end_next;
	logic [SEGS-1:0]                                    abort_reg, abort_next;
	logic [SEGS-1:0][seg_bus_pkg::EMPTY_W-1:0]          empty_reg, empty_next;
	logic                                               take;

	////////////////////////////////////////////////////////////////////////////
	// Launch one beat per grant; ready stays low while a beat is taken or on
	// the bus, because the grant seen in that cycle is one cycle stale
	always_comb begin
		take       = src_valid_in && ready_reg;
		ready_next = bus.tx_space && !take && !(|valid_reg);
		for (int s = 0; s < SEGS; s++) begin
			valid_next[s] = take && src_seg_valid_in[s];
			word_next[s]  = valid_next[s] ? src_word_in[s] : '0;
			end_next[s]   = valid_next[s] && src_last_in[s];
			abort_next[s] = end_next[s] && src_bad_in[s];
			empty_next[s] = end_next[s] ? src_empty_in[s] : '0;
		end
	end

	// Registers
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ready_reg <= 1'b0;
			valid_reg <= '0;
			word_reg  <= '0;
			end_reg   <= '0;
			abort_reg <= '0;
			empty_reg <= '0;
		end else begin
			ready_reg <= ready_next;
			valid_reg <= valid_next;
			word_reg  <= word_next;
			end_reg   <= end_next;
			abort_reg <= abort_next;
			empty_reg <= empty_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus drive, all from flip-flops
	assign src_ready_out        = ready_reg;
	assign bus.tx_segment_valid = valid_reg;
	assign bus.tx_segment_word  = word_reg;
	assign bus.tx_end_marker    = end_reg;
	assign bus.tx_abort_flag    = abort_reg;
	assign bus.tx_empty_count   = empty_reg;

endmodule
`default_nettype wire

//--- verilog/tx_seg_packet_end.sv
// MAC end: packet-end handling of the segmented transmit bus
//
// What this block does
// - Source raises end marker only on last transfer
// - End marker sampled only when segment valid
// - Source raises abort flag only to mark errored packet
// - Abort sampled only with valid and end marker
// - Aborted packet's last word becomes error code
// - Aborted packet skips frame check, that packet only
// - Source gives empty byte count on last transfer
// - Empty count sampled only with valid and end
// - Abort at end forces empty low bits zero
// - Four identical segments, each with own signals
// - Each segment carries a 128-bit word
// - Every bus signal sampled only when valid
`timescale 1ns/1ps
`default_nettype none
module tx_seg_packet_end (
	input  wire logic                                                        ref_clk_in,
	input  wire logic                                                        reset_in,
	seg_bus_if.device_end                                                    bus,
	input  wire logic                                                        out_ready_in,
	output logic                                                             out_valid_out,
	output logic      [seg_bus_pkg::SEG_COUNT-1:0]                           out_seg_valid_out,
	output logic      [seg_bus_pkg::SEG_COUNT-1:0][seg_bus_pkg::WORD_W-1:0]  out_word_out,
	output logic      [seg_bus_pkg::SEG_COUNT-1:0][seg_bus_pkg::WORD_BYTES-1:0] out_byte_en_out,
	output logic      [seg_bus_pkg::SEG_COUNT-1:0]                           out_end_out,
	output logic      [seg_bus_pkg::SEG_COUNT-1:0]                           out_fcs_off_out,
	output logic                                                             pkt_open_out,
	output logic                                                             overrun_out,
	output logic      [seg_bus_pkg::CNT_W-1:0]                               pkt_count_out,
	output logic      [seg_bus_pkg::CNT_W-1:0]                               abort_count_out
);

	localparam int SEGS   = seg_bus_pkg::SEG_COUNT;
	localparam int SLOT_W = seg_bus_pkg::SLOT_W;

	// Packet tracking across the four segments, lowest segment first
	typedef enum logic [1:0] {
		PKT_IDLE = 2'b01,
		PKT_OPEN = 2'b10
	} pkt_state_t;

	pkt_state_t                              state_reg, state_next;
	logic                                    space_reg, space_next;
	logic                                    overrun_reg, overrun_next;
	logic [seg_bus_pkg::CNT_W-1:0]           pkt_count_reg, pkt_count_next;
	logic [seg_bus_pkg::CNT_W-1:0]           abort_count_reg, abort_count_next;

	logic [SEGS-1:0]                         seg_take;
	logic [SEGS-1:0]                         seg_end;
	logic [SEGS-1:0]                         seg_abort;
	logic [SEGS-1:0][seg_bus_pkg::EMPTY_W-1:0] seg_empty;
	logic [SEGS*SLOT_W-1:0]                  in_slots;
	logic [SEGS*SLOT_W-1:0]                  out_slots;
	logic                                    any_take;
	logic                                    buf_in_ready;
	logic                                    buf_out_valid;

	////////////////////////////////////////////////////////////////////////////
	// Byte enables: lane b holds bits [8b+7:8b]; byte position 0 is the top
	// lane, so an empty count of n clears the lowest n lanes
	function automatic logic [seg_bus_pkg::WORD_BYTES-1:0] lane_mask(
		input logic [seg_bus_pkg::EMPTY_W-1:0] empty
	);
		logic [seg_bus_pkg::WORD_BYTES-1:0] m;
		m = '0;
		for (int b = 0; b < seg_bus_pkg::WORD_BYTES; b++) begin
			m[b] = (b >= int'(empty));
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Per-segment qualification; every segment is built the same way
	for (genvar s = 0; s < SEGS; s++) begin : g_seg
		logic [seg_bus_pkg::WORD_W-1:0]     word;
		logic [seg_bus_pkg::WORD_BYTES-1:0] mask;

		// Nothing on a segment counts unless its valid is high
		assign seg_take[s]  = bus.tx_segment_valid[s];
		assign seg_end[s]   = seg_take[s] && bus.tx_end_marker[s];
		assign seg_abort[s] = seg_end[s] && bus.tx_abort_flag[s];

		// Low empty bits are forced to zero on an aborted end, top bit kept
		always_comb begin
			seg_empty[s] = '0;
			if (seg_end[s]) begin
				seg_empty[s] = bus.tx_empty_count[s];
				if (seg_abort[s]) begin
					seg_empty[s][seg_bus_pkg::EMPTY_LOW_W-1:0] = '0;
				end
			end
		end

		// Aborted end word is replaced so the far receiver sees an error
		assign word = !seg_take[s] ? '0 :
			(seg_abort[s] ? seg_bus_pkg::ERROR_WORD : bus.tx_segment_word[s]);
		assign mask = seg_take[s] ? lane_mask(seg_empty[s]) : '0;

		// Frame check is skipped only on the aborted packet's end beat
		assign in_slots[s*SLOT_W +: SLOT_W] =
			{seg_take[s], seg_end[s], seg_abort[s], mask, word};

		// Unpack the buffered beat to the downstream ports
		assign out_seg_valid_out[s] = out_slots[s*SLOT_W + seg_bus_pkg::SLOT_VALID];
		assign out_end_out[s]       = out_slots[s*SLOT_W + seg_bus_pkg::SLOT_END];
		assign out_fcs_off_out[s]   = out_slots[s*SLOT_W + seg_bus_pkg::SLOT_ABORT];
		assign out_byte_en_out[s]   =
			out_slots[s*SLOT_W + seg_bus_pkg::SLOT_MASK_LSB +: seg_bus_pkg::WORD_BYTES];
		assign out_word_out[s]      = out_slots[s*SLOT_W +: seg_bus_pkg::WORD_W];
	end

	assign any_take = |seg_take;

	////////////////////////////////////////////////////////////////////////////
	// Beat buffer: a downstream stall parks up to two beats
	two_entry_buffer #(
		.WIDTH(SEGS*SLOT_W)
	) u_beat_buffer (
		.ref_clk_in   (ref_clk_in),
		.reset_in     (reset_in),
		.in_valid_in  (any_take),
		.in_ready_out (buf_in_ready),
		.in_data_in   (in_slots),
		.out_valid_out(buf_out_valid),
		.out_ready_in (out_ready_in),
		.out_data_out (out_slots)
	);

	////////////////////////////////////////////////////////////////////////////
	// Grant, overrun and statistics next state. The grant is conservative:
	// it is given only when the buffer is empty and the bus was idle, which
	// limits peak throughput to one beat every five cycles but keeps any in-flight beat from being lost.
	always_comb begin
		pkt_state_t st;
		st               = state_reg;
		space_next       = buf_in_ready && !buf_out_valid && !any_take;
		overrun_next     = overrun_reg || (any_take && !buf_in_ready);
		pkt_count_next   = pkt_count_reg;
		abort_count_next = abort_count_reg;
		if (!any_take || buf_in_ready) begin
			for (int s = 0; s < SEGS; s++) begin
				if (seg_take[s]) begin
					st = seg_end[s] ? PKT_IDLE : PKT_OPEN;
				end
				if (seg_end[s]) begin
					pkt_count_next = pkt_count_next + seg_bus_pkg::CNT_ONE;
				end
				if (seg_abort[s]) begin
					abort_count_next = abort_count_next + seg_bus_pkg::CNT_ONE;
				end
			end
		end
		case (st)
			PKT_IDLE: state_next = PKT_IDLE;
			PKT_OPEN: state_next = PKT_OPEN;
			default:  state_next = PKT_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg       <= PKT_IDLE;
			space_reg       <= 1'b0;
			overrun_reg     <= 1'b0;
			pkt_count_reg   <= seg_bus_pkg::CNT_RESET;
			abort_count_reg <= seg_bus_pkg::CNT_RESET;
		end else begin
			state_reg       <= state_next;
			space_reg       <= space_next;
			overrun_reg     <= overrun_next;
			pkt_count_reg   <= pkt_count_next;
			abort_count_reg <= abort_count_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops
	assign bus.tx_space        = space_reg;
	assign out_valid_out       = buf_out_valid;
	assign pkt_open_out        = state_reg[1]; // One-hot open bit, straight from the flop
	assign overrun_out         = overrun_reg; // Sticky until reset
	assign pkt_count_out       = pkt_count_reg;
	assign abort_count_out     = abort_count_reg;

endmodule
`default_nettype wire

//--- testbench/seg_bus_properties.sv
// Wire-level checks of the segmented transmit bus between both ends
`timescale 1ns/1ps
`default_nettype none
module seg_bus_properties (
	input  wire logic             ref_clk_in,
	input  wire logic             reset_in,
	input  wire logic [3:0]       tx_segment_valid,
	input  wire logic [3:0][127:0] tx_segment_word,
	input  wire logic [3:0]       tx_end_marker,
	input  wire logic [3:0]       tx_abort_flag,
	input  wire logic [3:0][3:0]  tx_empty_count,
	input  wire logic             tx_space
);
	logic [3:0] stray_empty;
	logic [3:0] stray_word;

	// Per-segment leftovers that a masked source must never show
	always_comb begin
		for (int s = 0; s < 4; s++) begin
			stray_empty[s] = !tx_end_marker[s] && (tx_empty_count[s] != 4'h0);
			stray_word[s]  = !tx_segment_valid[s] && (tx_segment_word[s] != 128'h0);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One clock domain, so clocking and disable are given once
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	AST_END_WITH_VALID: assert property ((tx_end_marker & ~tx_segment_valid) == 4'h0)
		else $error("end marker outside a valid segment");
	AST_ABORT_WITH_END: assert property ((tx_abort_flag & ~tx_end_marker) == 4'h0)
		else $error("abort flag without end marker");
	AST_EMPTY_AT_END: assert property (stray_empty == 4'h0)
		else $error("empty count off an end segment");
	AST_IDLE_WORD_ZERO: assert property (stray_word == 4'h0)
		else $error("word driven on an idle segment");
	AST_BEAT_ONE_CYCLE: assert property (|tx_segment_valid |=> tx_segment_valid == 4'h0)
		else $error("beat held longer than one cycle");
	AST_SPACE_CLOSES: assert property (|tx_segment_valid |=> !tx_space)
		else $error("space still granted after a beat");
	AST_LAUNCH_ON_SPACE: assert property (|tx_segment_valid |-> $past(tx_space))
		else $error("beat launched without space");
	AST_QUIET_AFTER_RESET: assert property ($fell(reset_in) |->
		tx_segment_valid == 4'h0 ##1 tx_segment_valid == 4'h0)
		else $error("beat too soon after reset");
endmodule
`default_nettype wire

//--- testbench/tx_segmented_bus_packet_end_tb_top.sv
// Bench driving both ends of the segmented transmit bus
`timescale 1ns/1ps
`default_nettype none
module tx_segmented_bus_packet_end_tb_top;
	typedef struct packed {
		logic [3:0]      sv;
		logic [3:0]      la;
		logic [3:0]      bd;
		logic [3:0][3:0] em;
		logic [7:0]      k;
	} beat_t;

	logic              ref_clk_in   = 1'b0;
	logic              reset_in     = 1'b1;
	logic              src_valid_in = 1'b0;
	logic              out_ready_in = 1'b0;
	beat_t             cur          = '0;
	logic [3:0][127:0] src_word;
	logic              src_ready_out;
	logic              out_valid_out;
	logic [3:0]        out_seg_valid_out;
	logic [3:0][127:0] out_word_out;
	logic [3:0][15:0]  out_byte_en_out;
	logic [3:0]        out_end_out;
	logic [3:0]        out_fcs_off_out;
	logic              pkt_open_out;
	logic              overrun_out;
	logic [15:0]       pkt_count_out;
	logic [15:0]       abort_count_out;
	logic [15:0]       exp_pkt      = 16'h0;
	logic [15:0]       exp_ab       = 16'h0;
	int                failures     = 0;
	int                check_count  = 0;
	beat_t             q[$];

	// 20 MHz clock
	always #25 ref_clk_in = ~ref_clk_in;

	// Word pattern carries beat and segment number, so swaps show up
	always_comb begin
		for (int s = 0; s < 4; s++) begin
			src_word[s] = {8{cur.k, 8'(s)}};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Both ends face each other across the interface
	seg_bus_if seg_bus_if_i ();
	tx_seg_source tx_seg_source_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.bus(seg_bus_if_i.user_end), .src_valid_in(src_valid_in), .src_ready_out(src_ready_out),
		.src_seg_valid_in(cur.sv), .src_word_in(src_word), .src_last_in(cur.la),
		.src_bad_in(cur.bd), .src_empty_in(cur.em));
	tx_seg_packet_end tx_seg_packet_end_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.bus(seg_bus_if_i.device_end), .out_ready_in(out_ready_in), .out_valid_out(out_valid_out),
		.out_seg_valid_out(out_seg_valid_out), .out_word_out(out_word_out),
		.out_byte_en_out(out_byte_en_out), .out_end_out(out_end_out),
		.out_fcs_off_out(out_fcs_off_out), .pkt_open_out(pkt_open_out),
		.overrun_out(overrun_out), .pkt_count_out(pkt_count_out),
		.abort_count_out(abort_count_out));
	seg_bus_properties seg_bus_properties_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.tx_segment_valid(seg_bus_if_i.tx_segment_valid),
		.tx_segment_word(seg_bus_if_i.tx_segment_word),
		.tx_end_marker(seg_bus_if_i.tx_end_marker), .tx_abort_flag(seg_bus_if_i.tx_abort_flag),
		.tx_empty_count(seg_bus_if_i.tx_empty_count), .tx_space(seg_bus_if_i.tx_space));

	////////////////////////////////////////////////////////////////////////////////
	// Compare and report helpers
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Offer one beat; called and left on a rising edge
	task automatic send(input beat_t b);
		int n;
		n = 0;
		cur <= b;
		src_valid_in <= 1'b1;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (src_ready_out !== 1'b1 && n < 60);
		src_valid_in <= 1'b0;
		if (n >= 60) begin
			failures++;
			tally_and_finish();
		end
		q.push_back(b);
		for (int s = 0; s < 4; s++) begin
			if (b.sv[s] && b.la[s]) begin
				exp_pkt++;
				exp_ab += 16'(b.bd[s]);
			end
		end
	endtask

	// Wait for the oldest beat downstream, judge it, then take it
	task automatic pop;
		beat_t      b;
		int         n;
		logic       ab;
		logic [3:0] eff;
		logic [15:0] be;
		b = q.pop_front();
		n = 0;
		#1;
		while (out_valid_out !== 1'b1 && n < 60) begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		if (n >= 60) begin
			failures++;
			tally_and_finish();
		end
		chk(128'(out_seg_valid_out), 128'(b.sv));
		for (int s = 0; s < 4; s++) begin
			if (b.sv[s]) begin
				ab  = b.la[s] & b.bd[s];
				eff = !b.la[s] ? 4'h0 : ab ? {b.em[s][3], 3'h0} : b.em[s];
				be  = 16'hffff << eff;
				chk(out_word_out[s], ab ? seg_bus_pkg::ERROR_WORD : {8{b.k, 8'(s)}});
				chk(128'(out_byte_en_out[s]), 128'(be));
				chk(128'(out_end_out[s]), 128'(b.la[s]));
				chk(128'(out_fcs_off_out[s]), 128'(ab));
			end
		end
		@(posedge ref_clk_in);
		out_ready_in <= 1'b1;
		@(posedge ref_clk_in);
		out_ready_in <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic sc_plain_end;
		send('{sv:4'hf, la:4'h8, bd:4'h0, em:16'h5000, k:8'ha1});
		pop();
		chk(128'(pkt_open_out), 128'h0);
	endtask

	task automatic sc_abort_end;
		send('{sv:4'h3, la:4'h2, bd:4'h2, em:16'h00d0, k:8'ha2});
		pop();
	endtask

	// Odd segments abort; stray empty and abort on non-end segments
	task automatic sc_each_segment;
		for (int s = 0; s < 4; s++) begin
			send('{sv:4'((1 << (s + 1)) - 1), la:4'(1 << s), bd:(s[0] ? 4'hf : 4'h0),
				em:16'hc7c7, k:8'(8'hc0 + s)});
			pop();
		end
	endtask

	task automatic sc_open_packet;
		send('{sv:4'hf, la:4'h0, bd:4'hf, em:16'hffff, k:8'hb1});
		pop();
		chk(128'(pkt_open_out), 128'h1);
		send('{sv:4'h1, la:4'h1, bd:4'h0, em:16'h0001, k:8'hb2});
		pop();
		chk(128'(pkt_open_out), 128'h0);
	endtask

	// Downstream stalls: the parked beat must hold and the grant stay closed
	task automatic sc_stall;
		send('{sv:4'h1, la:4'h1, bd:4'h0, em:16'h0003, k:8'hd1});
		repeat (6) @(posedge ref_clk_in);
		#1;
		chk(128'(seg_bus_if_i.tx_space), 128'h0);
		chk(128'(src_ready_out), 128'h0);
		chk(128'(out_valid_out), 128'h1);
		@(posedge ref_clk_in);
		pop();
		send('{sv:4'h3, la:4'h2, bd:4'h0, em:16'h0020, k:8'hd2});
		pop();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		sc_plain_end();
		sc_abort_end();
		sc_each_segment();
		sc_open_packet();
		sc_stall();
		chk(128'(pkt_count_out), 128'(exp_pkt));
		chk(128'(abort_count_out), 128'(exp_ab));
		chk(128'(overrun_out), 128'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
